// *** hw/uab_top.sv ***
// Auto-baud measurement, fractional baud generator and transmit gate.
// Assumes AXI4-Lite master on clk; rx_pin is asynchronous.
`default_nettype none

module uab_top #(
    parameter int CNT_W = uab_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire uab_pkg::uab_axil_req_t axi_i,
    output uab_pkg::uab_axil_rsp_t axi_o,
    input wire logic rx_pin,
    input wire logic tx_pending,
    input wire logic tx_idle,
    output logic tx_load,
    output logic baud16,
    output logic rsr_clear,
    output logic rsr_fast,
    output logic [15:0] divisor
);

    typedef struct packed {
        logic aw_v;
        logic [31:0] aw_a;
        logic w_v;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic b_v;
        logic [1:0] b_r;
        logic r_v;
        logic [31:0] r_d;
        logic [1:0] r_r;
        logic [2:0] rx;
        uab_pkg::uab_ab_state_t ab;
        logic ab_start;
        logic ab_mode;
        logic ab_rst_en;
        logic [CNT_W-1:0] cnt;
        logic [4:0] spl;
        logic rsr_clr;
        logic [3:0] f_add;
        logic [3:0] f_mul;
        logic gate;
        logic [15:0] dl;
        logic en_done;
        logic en_to;
        logic fl_done;
        logic fl_to;
    } uab_top_st_t;

    uab_top_st_t s;
    uab_top_st_t n;
    logic fall;
    logic rise;
    logic stop;
    logic fin;
    logic ovf;
    logic wr;
    logic [31:0] wm;
    logic [31:0] cur;
    logic frac_tick;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] d,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] rd_reg(
        input uab_top_st_t st,
        input logic [31:0] a
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            uab_pkg::ADDR_ACR: begin
                r[uab_pkg::ACR_START] = st.ab_start;
                r[uab_pkg::ACR_MODE] = st.ab_mode;
                r[uab_pkg::ACR_RESTART] = st.ab_rst_en;
            end
            uab_pkg::ADDR_FDR: begin
                r[uab_pkg::FDR_ADD_LSB +: 4] = st.f_add;
                r[uab_pkg::FDR_MUL_LSB +: 4] = st.f_mul;
            end
            uab_pkg::ADDR_TER: begin
                r[uab_pkg::TER_GATE] = st.gate;
            end
            uab_pkg::ADDR_DIV: begin
                r[15:0] = st.dl;
            end
            uab_pkg::ADDR_IRQ: begin
                r[uab_pkg::IRQ_DONE_EN] = st.en_done;
                r[uab_pkg::IRQ_TOUT_EN] = st.en_to;
                r[uab_pkg::IRQ_DONE_FL] = st.fl_done;
                r[uab_pkg::IRQ_TOUT_FL] = st.fl_to;
            end
            default: begin
                r = 32'h0000_0000;
            end
        endcase
        return r;
    endfunction

    function automatic logic known(input logic [31:0] a);
        return a == uab_pkg::ADDR_ACR || a == uab_pkg::ADDR_FDR ||
            a == uab_pkg::ADDR_TER || a == uab_pkg::ADDR_DIV ||
            a == uab_pkg::ADDR_IRQ;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n = s;
        fin = 1'b0;
        ovf = 1'b0;
        n.rsr_clr = 1'b0;
        n.rx = {s.rx[1:0], rx_pin};
        fall = s.rx[2] & ~s.rx[1];
        rise = ~s.rx[2] & s.rx[1];
        stop = s.ab_mode ? rise : fall;
        if (s.spl != 5'h00) begin
            n.spl = s.spl - 5'h01;
        end

        // Measurement
        case (s.ab)
            uab_pkg::AB_IDLE: begin
                n.ab = uab_pkg::AB_IDLE;
            end
            uab_pkg::AB_ARM: begin
                if (fall) begin
                    n.ab = uab_pkg::AB_COUNT;
                    n.cnt = '0;
                    n.spl = uab_pkg::SAMPLE_PULSES;
                end
            end
            uab_pkg::AB_COUNT: begin
                if (stop) begin
                    fin = 1'b1;
                    if (s.ab_mode) begin
                        n.dl = 16'(s.cnt >> uab_pkg::MODE1_SHIFT);
                    end else begin
                        n.dl = 16'(s.cnt >> uab_pkg::MODE0_SHIFT);
                    end
                    n.ab = uab_pkg::AB_IDLE;
                    n.ab_start = 1'b0;
                end else if (&s.cnt) begin
                    ovf = 1'b1;
                    n.cnt = '0;
                    if (s.ab_rst_en) begin
                        n.ab = uab_pkg::AB_ARM;
                    end else begin
                        n.ab = uab_pkg::AB_IDLE;
                        n.ab_start = 1'b0;
                    end
                end else begin
                    n.cnt = s.cnt + CNT_W'(1);
                end
            end
            default: begin
                n.ab = uab_pkg::AB_IDLE;
            end
        endcase

        // Write channels
        if (axi_i.awvalid && !s.aw_v && !s.b_v) begin
            n.aw_v = 1'b1;
            n.aw_a = axi_i.awaddr;
        end
        if (axi_i.wvalid && !s.w_v && !s.b_v) begin
            n.w_v = 1'b1;
            n.w_d = axi_i.wdata;
            n.w_s = axi_i.wstrb;
        end
        if (s.b_v && axi_i.bready) begin
            n.b_v = 1'b0;
        end
        wr = s.aw_v && s.w_v;
        cur = rd_reg(s, s.aw_a);
        wm = merge(cur, s.w_d, s.w_s);
        if (wr) begin
            n.aw_v = 1'b0;
            n.w_v = 1'b0;
            n.b_v = 1'b1;
            n.b_r = known(s.aw_a) ? uab_pkg::RESP_OKAY : uab_pkg::RESP_SLVERR;
            case (s.aw_a)
                uab_pkg::ADDR_ACR: begin
                    n.ab_mode = wm[uab_pkg::ACR_MODE];
                    n.ab_rst_en = wm[uab_pkg::ACR_RESTART];
                    if (!wm[uab_pkg::ACR_START]) begin
                        n.ab_start = 1'b0;
                        n.ab = uab_pkg::AB_IDLE;
                        n.spl = 5'h00;
                    end else if (!s.ab_start) begin
                        n.ab_start = 1'b1;
                        n.ab = uab_pkg::AB_ARM;
                        n.cnt = '0;
                        n.spl = 5'h00;
                        n.rsr_clr = 1'b1;
                    end
                    if (s.w_s[1] && s.w_d[uab_pkg::ACR_DONE_CLR]) begin
                        n.fl_done = 1'b0;
                    end
                    if (s.w_s[1] && s.w_d[uab_pkg::ACR_TOUT_CLR]) begin
                        n.fl_to = 1'b0;
                    end
                end
                uab_pkg::ADDR_FDR: begin
                    n.f_add = wm[uab_pkg::FDR_ADD_LSB +: 4];
                    n.f_mul = wm[uab_pkg::FDR_MUL_LSB +: 4];
                end
                uab_pkg::ADDR_TER: begin
                    n.gate = wm[uab_pkg::TER_GATE];
                end
                uab_pkg::ADDR_DIV: begin
                    n.dl = wm[15:0];
                end
                uab_pkg::ADDR_IRQ: begin
                    n.en_done = wm[uab_pkg::IRQ_DONE_EN];
                    n.en_to = wm[uab_pkg::IRQ_TOUT_EN];
                end
                default: begin
                    n.b_r = uab_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Flag sets win over clears
        if (fin && s.en_done) begin
            n.fl_done = 1'b1;
        end
        if (ovf && s.en_to) begin
            n.fl_to = 1'b1;
        end

        // Read channel
        if (s.r_v && axi_i.rready) begin
            n.r_v = 1'b0;
        end
        if (axi_i.arvalid && !s.r_v) begin
            n.r_v = 1'b1;
            n.r_d = rd_reg(s, axi_i.araddr);
            n.r_r = known(axi_i.araddr) ? uab_pkg::RESP_OKAY : uab_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.rx <= 3'h7;
            s.ab <= uab_pkg::AB_IDLE;
            s.f_add <= uab_pkg::FDR_ADD_RST;
            s.f_mul <= uab_pkg::FDR_MUL_RST;
            s.gate <= uab_pkg::TER_GATE_RST;
            s.dl <= uab_pkg::DIV_RST;
        end else if (ce) begin
            s <= n;
        end
    end

    // ----------------------------------------
    // Baud generator
    // ----------------------------------------
    uab_fracdiv #(
        .DW(16)
    ) u_fracdiv (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .hold(s.ab_start),
        .dl(s.dl),
        .add(s.f_add),
        .mul(s.f_mul),
        .tick(frac_tick)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign baud16 = s.ab_start ? (ce && s.spl != 5'h00) : frac_tick;
    assign rsr_fast = s.ab_start;
    assign rsr_clear = s.rsr_clr;
    assign divisor = s.dl;
    assign tx_load = s.gate & tx_pending & tx_idle;
    assign axi_o.awready = !s.aw_v && !s.b_v;
    assign axi_o.wready = !s.w_v && !s.b_v;
    assign axi_o.bvalid = s.b_v;
    assign axi_o.bresp = s.b_r;
    assign axi_o.arready = !s.r_v;
    assign axi_o.rvalid = s.r_v;
    assign axi_o.rdata = s.r_d;
    assign axi_o.rresp = s.r_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b || !ce);

    logic acr_wr;
    assign acr_wr = wr && s.aw_a == uab_pkg::ADDR_ACR;

    start_reset_a: assert property (
        acr_wr && wm[uab_pkg::ACR_START] && !s.ab_start
        |=> rsr_clear && rsr_fast && s.cnt == '0 && s.ab == uab_pkg::AB_ARM)
        else $error("start did not clear counter and shift register");
    sample_burst_a: assert property (
        s.ab == uab_pkg::AB_ARM && fall && !wr
        |=> baud16[*8] ##1 baud16[*8])
        else $error("start bit did not get sixteen sample pulses");
    mode1_stop_a: assert property (
        s.ab == uab_pkg::AB_COUNT && s.ab_mode && rise && !wr
        |=> s.ab == uab_pkg::AB_IDLE && !s.ab_start)
        else $error("mode 1 did not stop on rising edge");
    mode0_hold_a: assert property (
        s.ab == uab_pkg::AB_COUNT && !s.ab_mode && rise && !wr && !(&s.cnt)
        |=> s.ab == uab_pkg::AB_COUNT && s.cnt == $past(s.cnt) + CNT_W'(1))
        else $error("mode 0 stopped on a rising edge");
    load_div_a: assert property (
        s.ab == uab_pkg::AB_COUNT && s.ab_mode && rise && !wr
        |=> divisor == 16'($past(s.cnt) >> uab_pkg::MODE1_SHIFT))
        else $error("measured count not loaded into latches");
    done_flag_a: assert property (
        fin && s.en_done |=> s.fl_done)
        else $error("done flag not raised");
    tout_flag_a: assert property (
        ovf && s.en_to |=> s.fl_to)
        else $error("timeout flag not raised");
    rearm_a: assert property (
        ovf && s.ab_rst_en && !wr |=> s.ab == uab_pkg::AB_ARM && s.ab_start)
        else $error("timeout with restart did not rearm");
    flag_clear_a: assert property (
        acr_wr && s.w_s[1] && s.w_d[uab_pkg::ACR_DONE_CLR] && !(fin && s.en_done)
        |=> !s.fl_done)
        else $error("done flag survived a clear");
    gate_block_a: assert property (
        !s.gate |-> !tx_load)
        else $error("character moved while gate closed");

    done_c: cover property (fin && s.en_done);
    restart_c: cover property (ovf && s.ab_rst_en);
    gate_c: cover property (tx_load);

endmodule

`default_nettype wire

// *** pkg/uab_pkg.sv ***
// Constants and carriers for the auto-baud and fractional baud block.
// Assumes an AXI4-Lite master with 32-bit data on the peripheral clock.
`default_nettype none

package uab_pkg;

    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [31:0] ADDR_ACR = 32'h4000_8020;
    localparam logic [31:0] ADDR_FDR = 32'h4000_8028;
    localparam logic [31:0] ADDR_TER = 32'h4000_8030;
    localparam logic [31:0] ADDR_DIV = 32'h4000_8040;
    localparam logic [31:0] ADDR_IRQ = 32'h4000_8044;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int ACR_START = 0;
    localparam int ACR_MODE = 1;
    localparam int ACR_RESTART = 2;
    localparam int ACR_DONE_CLR = 8;
    localparam int ACR_TOUT_CLR = 9;
    localparam int FDR_ADD_LSB = 0;
    localparam int FDR_MUL_LSB = 4;
    localparam int TER_GATE = 7;
    localparam int DIV_HIGH_LSB = 8;
    localparam int IRQ_DONE_EN = 0;
    localparam int IRQ_TOUT_EN = 1;
    localparam int IRQ_DONE_FL = 8;
    localparam int IRQ_TOUT_FL = 9;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [3:0] FDR_ADD_RST = 4'h0;
    localparam logic [3:0] FDR_MUL_RST = 4'h1;
    localparam logic TER_GATE_RST = 1'b1;
    localparam logic [15:0] DIV_RST = 16'h0001;

    // ----------------------------------------
    // Counts
    // ----------------------------------------
    localparam int CNT_W = 20;
    localparam logic [4:0] SAMPLE_PULSES = 5'h10;
    localparam int MODE0_SHIFT = 5;
    localparam int MODE1_SHIFT = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        AB_IDLE = 3'h1,
        AB_ARM = 3'h2,
        AB_COUNT = 3'h4
    } uab_ab_state_t;

    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } uab_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } uab_axil_rsp_t;

endpackage

`default_nettype wire

// *** hw/uab_fracdiv.sv ***
// Fractional pre-scaler and 16x baud tick generator.
// Assumes divisor and fraction fields steady while characters move.
`default_nettype none

module uab_fracdiv #(
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic hold,
    input wire logic [DW-1:0] dl,
    input wire logic [3:0] add,
    input wire logic [3:0] mul,
    output logic tick
);

    typedef struct packed {
        logic [DW-1:0] cnt;
        logic [3:0] acc;
        logic str;
        logic tick;
    } uab_fd_st_t;

    uab_fd_st_t s;
    uab_fd_st_t n;
    logic [4:0] sum;
    logic last;

    // ----------------------------------------
    // Divider
    // ----------------------------------------
    always_comb begin
        n = s;
        n.tick = 1'b0;
        sum = {1'b0, s.acc} + {1'b0, add};
        last = ({1'b0, s.cnt} + (DW+1)'(1)) >= {1'b0, dl};
        if (hold) begin
            n.cnt = '0;
            n.acc = 4'h0;
            n.str = 1'b0;
        end else if (!last) begin
            n.cnt = s.cnt + DW'(1);
        end else begin
            n.cnt = '0;
            if (add == 4'h0) begin
                n.tick = 1'b1;
            end else if (s.str) begin
                n.str = 1'b0;
            end else begin
                n.tick = 1'b1;
                if (sum >= {1'b0, mul}) begin
                    n.acc = 4'(sum - {1'b0, mul});
                    n.str = 1'b1;
                end else begin
                    n.acc = sum[3:0];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end

    assign tick = s.tick & ce;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [DW:0] gap_q;
    logic seen_q;
    logic [DW-1:0] dl_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_q <= '0;
            seen_q <= 1'b0;
            dl_q <= '0;
        end else if (ce) begin
            gap_q <= (s.tick || hold) ? (DW+1)'(1) : gap_q + (DW+1)'(1);
            dl_q <= dl;
            // A divisor change mid-period leaves one period of mixed length
            seen_q <= (hold || dl != dl_q) ? 1'b0 : (seen_q | s.tick);
        end
    end

    bypass_period_a: assert property (@(posedge clk) disable iff (!rst_b || !ce)
        s.tick && seen_q && add == 4'h0 && dl > 0 && $stable(dl) |-> gap_q == {1'b0, dl})
        else $error("bypassed divider period differs from divisor");
    stretch_a: assert property (@(posedge clk) disable iff (!rst_b || !ce)
        !hold && last && add != 4'h0 && s.str |=> !s.tick && !s.str)
        else $error("fractional stretch period emitted a tick");
    stretch_c: cover property (@(posedge clk) disable iff (!rst_b) s.str && s.tick);

endmodule

`default_nettype wire

// *** testbench/uab_sender.sv ***
// Remote serial sender model driving the receive line.
// Assumes one frame at a time, started by a one-cycle go pulse.
`default_nettype none

module uab_sender (
    input wire logic clk,
    input wire logic go,
    input wire logic [15:0] bit_len,
    input wire logic [7:0] char_val,
    output logic rx,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] frame;
    initial begin
        rx = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'b1;
                frame = {1'b1, char_val, 1'b0};
                for (int i = 0; i < 10; i++) begin
                    rx <= frame[i];
                    repeat (bit_len) @(posedge clk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// *** testbench/tb_uart_autobaud_fractional_baudgen.sv ***
// Self-checking bench for the auto-baud and fractional baud block.
// Assumes the sender model and a counter width cut to 10 bits.
`default_nettype none

module tb_uart_autobaud_fractional_baudgen;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SLOW = 600;
    localparam int FAST = 168;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic tx_pending = 1'b0;
    logic tx_idle = 1'b0;
    logic go = 1'b0;
    logic [15:0] bit_len = 16'h0001;
    logic rx, busy, tx_load, baud16, rsr_clear, rsr_fast;
    logic [15:0] divisor;
    uab_pkg::uab_axil_req_t req = '0;
    uab_pkg::uab_axil_rsp_t rsp;
    int errors = 0;
    int checks_done = 0;
    int n16 = 0;
    int nclr = 0;
    int n;
    logic [31:0] rv;
    logic [1:0] rr;

    always #2 clk = ~clk;

    uab_top #(.CNT_W(10)) i_dut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .axi_i(req),
        .axi_o(rsp), .rx_pin(rx), .tx_pending(tx_pending), .tx_idle(tx_idle),
        .tx_load(tx_load), .baud16(baud16), .rsr_clear(rsr_clear), .rsr_fast(rsr_fast),
        .divisor(divisor));

    uab_sender i_snd (.clk(clk), .go(go), .bit_len(bit_len), .char_val(8'h41), .rx(rx),
        .busy(busy));

    always @(posedge clk) begin
        if (rsr_fast === 1'b1 && baud16 === 1'b1) n16 <= n16 + 1;
        if (rsr_clear === 1'b1) nclr <= nclr + 1;
    end

    // ----------------------------------------
    // Bus and check helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        rr = rsp.bresp;
    endtask

    task automatic rd(input logic [31:0] a);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        rv = rsp.rdata;
        rr = rsp.rresp;
    endtask

    task automatic send(input int bl);
        bit_len <= bl[15:0];
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        while (busy !== 1'b0) @(posedge clk);
    endtask

    task automatic ticks(input int span);
        while (baud16 !== 1'b1) @(posedge clk);
        n = 0;
        repeat (span) begin
            @(posedge clk);
            if (baud16 === 1'b1) n++;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd(uab_pkg::ADDR_FDR);
        chk(rv & 32'h0000_00ff, 32'h0000_0010);
        rd(uab_pkg::ADDR_TER);
        chk(rv & 32'h0000_0080, 32'h0000_0080);
        chk({16'h0000, divisor}, 32'h0000_0001);
        rd(32'h4000_8038);
        chk({30'h0, rr}, {30'h0, uab_pkg::RESP_SLVERR});
        wr(32'h4000_803c, 32'h0000_0001);
        chk({30'h0, rr}, {30'h0, uab_pkg::RESP_SLVERR});
        $display("test reset done");
    endtask

    task automatic t_gate();
        tx_pending <= 1'b1;
        tx_idle <= 1'b1;
        @(posedge clk);
        chk({31'h0, tx_load}, 32'h0000_0001);
        wr(uab_pkg::ADDR_TER, 32'h0000_0000);
        chk({31'h0, tx_load}, 32'h0000_0000);
        wr(uab_pkg::ADDR_TER, 32'h0000_0080);
        chk({31'h0, tx_load}, 32'h0000_0001);
        tx_idle <= 1'b0;
        @(posedge clk);
        chk({31'h0, tx_load}, 32'h0000_0000);
        $display("test gate done");
    endtask

    task automatic t_frac();
        wr(uab_pkg::ADDR_DIV, 32'h0000_0005);
        wr(uab_pkg::ADDR_FDR, 32'h0000_0010);
        ticks(300);
        chk(n, 60);
        wr(uab_pkg::ADDR_DIV, 32'h0000_0004);
        wr(uab_pkg::ADDR_FDR, 32'h0000_0021);
        rd(uab_pkg::ADDR_FDR);
        chk(rv & 32'h0000_00ff, 32'h0000_0021);
        ticks(120);
        chk({31'h0, n >= 19 && n <= 21}, 32'h0000_0001);
        wr(uab_pkg::ADDR_FDR, 32'h0000_0010);
        $display("test fractional done");
    endtask

    task automatic t_meas(input logic mode, input logic [31:0] en, input logic [31:0] fl);
        wr(uab_pkg::ADDR_DIV, 32'h0000_0001);
        wr(uab_pkg::ADDR_IRQ, en);
        n16 <= 0;
        nclr <= 0;
        wr(uab_pkg::ADDR_ACR, {30'h0, mode, 1'b1});
        repeat (2) @(posedge clk);
        chk({31'h0, rsr_fast}, 32'h0000_0001);
        chk(nclr, 1);
        send(FAST);
        chk({16'h0, divisor}, mode ? FAST >> 4 : (2 * FAST) >> 5);
        chk(n16, 16);
        rd(uab_pkg::ADDR_ACR);
        chk(rv & 32'h0000_0001, 32'h0000_0000);
        rd(uab_pkg::ADDR_IRQ);
        chk(rv & 32'h0000_0300, fl);
        $display("test measure done");
    endtask

    task automatic t_flags();
        wr(uab_pkg::ADDR_ACR, 32'h0000_0200);
        rd(uab_pkg::ADDR_IRQ);
        chk(rv & 32'h0000_0100, 32'h0000_0100);
        wr(uab_pkg::ADDR_ACR, 32'h0000_0100);
        rd(uab_pkg::ADDR_IRQ);
        chk(rv & 32'h0000_0100, 32'h0000_0000);
        wr(uab_pkg::ADDR_ACR, 32'h0000_0001);
        wr(uab_pkg::ADDR_ACR, 32'h0000_0000);
        @(posedge clk);
        chk({31'h0, rsr_fast}, 32'h0000_0000);
        $display("test flags done");
    endtask

    task automatic t_timeout();
        wr(uab_pkg::ADDR_IRQ, 32'h0000_0003);
        wr(uab_pkg::ADDR_ACR, 32'h0000_0001);
        send(SLOW);
        rd(uab_pkg::ADDR_ACR);
        chk(rv & 32'h0000_0001, 32'h0000_0000);
        rd(uab_pkg::ADDR_IRQ);
        chk(rv & 32'h0000_0300, 32'h0000_0200);
        wr(uab_pkg::ADDR_ACR, 32'h0000_0200);
        rd(uab_pkg::ADDR_IRQ);
        chk(rv & 32'h0000_0200, 32'h0000_0000);
        wr(uab_pkg::ADDR_ACR, 32'h0000_0005);
        send(SLOW);
        rd(uab_pkg::ADDR_ACR);
        chk(rv & 32'h0000_0001, 32'h0000_0001);
        rd(uab_pkg::ADDR_IRQ);
        chk(rv & 32'h0000_0200, 32'h0000_0200);
        wr(uab_pkg::ADDR_ACR, 32'h0000_0205);
        send(FAST);
        chk({16'h0, divisor}, (2 * FAST) >> 5);
        rd(uab_pkg::ADDR_IRQ);
        chk(rv & 32'h0000_0300, 32'h0000_0100);
        $display("test timeout done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #(4 * 60000);
        errors++;
        conclude();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        t_gate();
        t_frac();
        t_meas(1'b0, 32'h0000_0001, 32'h0000_0100);
        t_flags();
        t_meas(1'b1, 32'h0000_0000, 32'h0000_0000);
        t_timeout();
        conclude();
    end
endmodule

`default_nettype wire
